// ==== sbc_pkg.sv ====
// constants for the sideband configuration access slave
package sbc_pkg;
  localparam int BYTE_W = 8;
  localparam logic [3:0] BITS_LAST = 4'h7;
  localparam logic [3:0] BITS_DONE = 4'h8;
  // upper four address bits (6..3); bits 2..0 come from the straps
  localparam logic [3:0] SMB_ADDR_HI = 4'hB;
  localparam logic [3:0] I2C_ADDR_HI = 4'h7;
  localparam logic [7:0] SMB_CMD_CFG = 8'h08;
  localparam logic [7:0] SMB_PORT_MAX = 8'h03;
  localparam logic [3:0] SMB_WR_BE = 4'h3;
  localparam logic [2:0] I2C_CMD_WRITE = 3'h3;
  // byte positions counted from the address byte
  localparam logic [3:0] IDX_ADDR = 4'h0;
  localparam logic [3:0] IDX_CMD = 4'h1;
  localparam logic [3:0] IDX_OFFSET = 4'h2;
  localparam logic [3:0] IDX_PORT = 4'h3;
  localparam logic [3:0] IDX_CMD_LAST = 4'h4;
  localparam logic [3:0] IDX_DATA_LAST = 4'h8;
  localparam logic [3:0] IDX_MAX = 4'hF;
  // field positions inside the i2c command bytes
  localparam int CMD_CODE_HI = 2;
  localparam int BE_HI = 5;
  localparam int BE_LO = 2;
  localparam int PSEL_HI_BIT = 0;
  localparam int PSEL_LO_BIT = 7;
  localparam int ADDR_HI_HI = 1;
  localparam logic [1:0] ADDR_LOW_ZERO = 2'h0;
  localparam logic [3:0] SMB_ADDR_PAD = 4'h0;
  localparam logic [15:0] SMB_DATA_PAD = 16'h0000;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  // synchroniser reset: clock and data idle high, straps low
  localparam logic [4:0] SYNC_IDLE = 5'h18;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK_WAIT, ST_ACK, ST_TX, ST_RACK, ST_SKIP} sbc_state_e;
endpackage : sbc_pkg

// ==== sbc_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sbc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // reset to the idle level so no false edge follows reset
      meta <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : sbc_sync
`default_nettype wire

// ==== sbc_slave.sv ====
// two-wire sideband slave giving config register access (smbus and i2c)
`timescale 1ns/10ps
`default_nettype none
module sbc_slave
  import sbc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sideband_serial_clock_pin,
  input wire logic sideband_serial_data_pin_in,
  output logic sideband_serial_data_pin_out,
  output logic sideband_serial_data_pin_oe,
  input wire logic [2:0] addr_strap,
  output logic cfg_wr_req,
  output logic cfg_rd_req,
  output logic [1:0] cfg_port,
  output logic [11:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rd_valid
);
  logic scl_s, sda_s, scl_q, sda_q;
  logic [2:0] strap_s;
  sbc_sync #(.W(5), .RST_VAL(SYNC_IDLE)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .din({sideband_serial_clock_pin, sideband_serial_data_pin_in, addr_strap}),
    .dout({scl_s, sda_s, strap_s})
  );

  sbc_state_e state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt, byte_idx, next_byte_idx;
  logic [7:0] shreg, next_shreg, offset, next_offset, data_lo, next_data_lo;
  logic [7:0] cmd0, next_cmd0, cmd1, next_cmd1, cmd2, next_cmd2, cmd3, next_cmd3;
  logic [31:0] wbuf, next_wbuf, next_wdata;
  logic [15:0] rdata_q, next_rdata_q;
  logic oe, next_oe, ack, next_ack, tx_after, next_tx_after, skip, next_skip;
  logic mode_i2c, next_mode_i2c, armed, next_armed, rd_done, next_rd_done;
  logic cmd_ok, next_cmd_ok, tx_hi, next_tx_hi, next_wr_req, next_rd_req;
  logic [1:0] next_port;
  logic [11:0] next_addr;
  logic [3:0] next_be;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] rx_byte;
  logic [6:0] smb_addr, i2c_addr;

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c = scl_s & scl_q & ~sda_q & sda_s;
  assign rx_byte = {shreg[6:0], sda_s};
  assign smb_addr = {SMB_ADDR_HI, strap_s};
  assign i2c_addr = {I2C_ADDR_HI, strap_s};

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_byte_idx = byte_idx;
    next_shreg = shreg;
    next_offset = offset;
    next_data_lo = data_lo;
    next_cmd0 = cmd0;
    next_cmd1 = cmd1;
    next_cmd2 = cmd2;
    next_cmd3 = cmd3;
    next_wbuf = wbuf;
    next_rdata_q = rdata_q;
    next_oe = oe;
    next_ack = ack;
    next_tx_after = tx_after;
    next_skip = skip;
    next_mode_i2c = mode_i2c;
    next_armed = armed;
    next_rd_done = rd_done;
    next_cmd_ok = cmd_ok;
    next_tx_hi = tx_hi;
    next_wr_req = 1'b0;
    next_rd_req = 1'b0;
    next_port = cfg_port;
    next_addr = cfg_addr;
    next_be = cfg_be;
    next_wdata = cfg_wdata;
    // read data from the core; no link state gates this path
    if (cfg_rd_valid) begin
      next_rdata_q = cfg_rdata[15:0];
      next_rd_done = 1'b1;
    end
    if (stop_c) begin
      next_state = ST_IDLE;
      next_oe = 1'b0;
    end else if (start_c) begin
      // repeated start keeps the armed smbus offset for the read
      next_state = ST_RX;
      next_oe = 1'b0;
      next_bit_cnt = '0;
      next_byte_idx = IDX_ADDR;
    end else begin
      case (state)
        ST_RX: begin
          if (scl_rise) begin
            next_shreg = rx_byte;
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == BITS_LAST) begin
              next_state = ST_ACK_WAIT;
              next_ack = 1'b1;
              next_tx_after = 1'b0;
              next_skip = 1'b0;
              next_byte_idx = (byte_idx == IDX_MAX) ? IDX_MAX : byte_idx + 4'h1;
              if (byte_idx == IDX_ADDR) begin
                next_cmd_ok = 1'b0;
                if (rx_byte[7:1] == smb_addr) begin
                  next_mode_i2c = 1'b0;
                  if (rx_byte[0]) begin
                    next_ack = armed & rd_done;
                    next_skip = ~(armed & rd_done);
                    next_tx_after = armed & rd_done;
                    // a served read disarms; the next offset/port frame is a new read
                    next_armed = armed & ~rd_done;
                    next_shreg = rdata_q[7:0];
                    next_tx_hi = 1'b0;
                  end
                end else if (rx_byte[7:1] == i2c_addr) begin
                  // i2c register reads are not served here
                  next_mode_i2c = 1'b1;
                  next_ack = ~rx_byte[0];
                  next_skip = rx_byte[0];
                end else begin
                  next_ack = 1'b0;
                  next_skip = 1'b1;
                end
              end else if (!mode_i2c) begin
                if (byte_idx == IDX_CMD) begin
                  next_cmd_ok = (rx_byte == SMB_CMD_CFG);
                  next_ack = (rx_byte == SMB_CMD_CFG);
                end else if (!cmd_ok || byte_idx > IDX_PORT) begin
                  next_ack = 1'b0;
                end else if (byte_idx == IDX_OFFSET) begin
                  if (armed) next_data_lo = rx_byte;
                  else next_offset = rx_byte;
                end else if (armed) begin
                  next_wr_req = 1'b1;
                  next_armed = 1'b0;
                  next_addr = {SMB_ADDR_PAD, offset};
                  next_be = SMB_WR_BE;
                  next_wdata = {SMB_DATA_PAD, rx_byte, data_lo};
                end else if (rx_byte <= SMB_PORT_MAX) begin
                  next_port = rx_byte[1:0];
                  next_addr = {SMB_ADDR_PAD, offset};
                  next_armed = 1'b1;
                  next_rd_req = 1'b1;
                  next_rd_done = 1'b0;
                end else begin
                  next_ack = 1'b0;
                  next_armed = 1'b0;
                end
              end else begin
                case (byte_idx)
                  IDX_CMD: next_cmd0 = rx_byte;
                  IDX_OFFSET: next_cmd1 = rx_byte;
                  IDX_PORT: next_cmd2 = rx_byte;
                  IDX_CMD_LAST: next_cmd3 = rx_byte;
                  default: next_wbuf = {wbuf[23:0], rx_byte};
                endcase
                if (byte_idx > IDX_DATA_LAST) begin
                  next_ack = 1'b0;
                end else if (byte_idx == IDX_DATA_LAST &&
                             cmd0[CMD_CODE_HI:0] == I2C_CMD_WRITE) begin
                  next_wr_req = 1'b1;
                  next_port = {cmd1[PSEL_HI_BIT], cmd2[PSEL_LO_BIT]};
                  next_addr = {cmd2[ADDR_HI_HI:0], cmd3, ADDR_LOW_ZERO};
                  next_be = cmd2[BE_HI:BE_LO];
                  next_wdata = {wbuf[23:0], rx_byte};
                end
              end
            end
          end
        end
        ST_ACK_WAIT: begin
          if (scl_fall) begin
            next_oe = ack;
            next_state = ST_ACK;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_bit_cnt = '0;
            if (tx_after) begin
              next_oe = ~shreg[7];
              next_state = ST_TX;
            end else begin
              next_oe = 1'b0;
              next_state = skip ? ST_SKIP : ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) next_bit_cnt = bit_cnt + 4'h1;
          if (scl_fall) begin
            if (bit_cnt == BITS_DONE) begin
              next_oe = 1'b0;
              next_state = ST_RACK;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe = ~shreg[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              next_state = ST_SKIP;
            end else begin
              // a master that acks past byte two only sees released sda
              next_shreg = tx_hi ? IDLE_BYTE : rdata_q[15:8];
              next_tx_hi = 1'b1;
              next_tx_after = 1'b1;
              next_state = ST_ACK;
            end
          end
        end
        ST_SKIP: next_oe = 1'b0;
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_cnt <= '0;
      byte_idx <= '0;
      shreg <= '0;
      offset <= '0;
      data_lo <= '0;
      cmd0 <= '0;
      cmd1 <= '0;
      cmd2 <= '0;
      cmd3 <= '0;
      wbuf <= '0;
      rdata_q <= '0;
      oe <= 1'b0;
      ack <= 1'b0;
      tx_after <= 1'b0;
      skip <= 1'b0;
      mode_i2c <= 1'b0;
      armed <= 1'b0;
      rd_done <= 1'b0;
      cmd_ok <= 1'b0;
      tx_hi <= 1'b0;
      cfg_wr_req <= 1'b0;
      cfg_rd_req <= 1'b0;
      cfg_port <= '0;
      cfg_addr <= '0;
      cfg_be <= '0;
      cfg_wdata <= '0;
      sideband_serial_data_pin_out <= 1'b0;
      sideband_serial_data_pin_oe <= 1'b0;
    end else begin
      state <= next_state;
      scl_q <= scl_s;
      sda_q <= sda_s;
      bit_cnt <= next_bit_cnt;
      byte_idx <= next_byte_idx;
      shreg <= next_shreg;
      offset <= next_offset;
      data_lo <= next_data_lo;
      cmd0 <= next_cmd0;
      cmd1 <= next_cmd1;
      cmd2 <= next_cmd2;
      cmd3 <= next_cmd3;
      wbuf <= next_wbuf;
      rdata_q <= next_rdata_q;
      oe <= next_oe;
      ack <= next_ack;
      tx_after <= next_tx_after;
      skip <= next_skip;
      mode_i2c <= next_mode_i2c;
      armed <= next_armed;
      rd_done <= next_rd_done;
      cmd_ok <= next_cmd_ok;
      tx_hi <= next_tx_hi;
      cfg_wr_req <= next_wr_req;
      cfg_rd_req <= next_rd_req;
      cfg_port <= next_port;
      cfg_addr <= next_addr;
      cfg_be <= next_be;
      cfg_wdata <= next_wdata;
      // open drain: only ever pulls low
      sideband_serial_data_pin_out <= 1'b0;
      sideband_serial_data_pin_oe <= next_oe;
    end
  end

  chk_ack_drive: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_ACK_WAIT && scl_fall && !stop_c && !start_c) |=> (sideband_serial_data_pin_oe == ack))
    else $error("ack bit not driven as decided");
  chk_addr_match: assert property (@(posedge ref_clk) disable iff (rst)
    // a served read has already swapped the address for read data
    (state == ST_ACK && ack && !tx_after && byte_idx == IDX_CMD) |->
    (mode_i2c ? (shreg[7:1] == i2c_addr) : (shreg[7:1] == smb_addr)))
    else $error("acked an address that is not ours");
  chk_extra_nack: assert property (@(posedge ref_clk) disable iff (rst)
    // byte_idx already counts the byte whose ack is pending
    (state == ST_ACK_WAIT && mode_i2c && byte_idx > IDX_DATA_LAST + 4'h1) |-> !ack)
    else $error("extra i2c data byte acknowledged");
  chk_bad_cmd: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg_wr_req && mode_i2c) |-> ($past(cmd0[CMD_CODE_HI:0]) == I2C_CMD_WRITE))
    else $error("write issued for invalid command");
  chk_be_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg_wr_req && mode_i2c) |->
    (cfg_be == cmd2[BE_HI:BE_LO] && cfg_addr == {cmd2[ADDR_HI_HI:0], cmd3, ADDR_LOW_ZERO}))
    else $error("byte enables or address wrong");
  chk_byte_order: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg_wr_req && mode_i2c) |-> (cfg_wdata[31:8] == $past(wbuf[23:0])))
    else $error("i2c data bytes out of order");
  chk_port_range: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_rd_req |-> ($past(rx_byte) <= SMB_PORT_MAX && armed))
    else $error("read issued for reserved port");
  chk_read_release: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_RACK) |-> !sideband_serial_data_pin_oe)
    else $error("sda held during master ack");
  chk_req_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr_req |=> !cfg_wr_req ##1 !cfg_wr_req)
    else $error("write request longer than a pulse");
endmodule : sbc_slave
`default_nettype wire

// ==== sbc_master.sv ====
// bus master model for the two-wire sideband bus
`timescale 1ns/10ps
`default_nettype none
module sbc_master (
  input wire logic ref_clk,
  input wire logic sideband_serial_data_pin,
  output logic sideband_serial_clock_pin,
  output logic sideband_serial_data_pin_oe
);
  // quarter bit in ref_clk cycles: 200 ns bus clock; slave answers 3 cycles after a fall
  localparam int QTR = 2;
  logic scl = 1'b1;
  logic oe = 1'b0;
  assign sideband_serial_clock_pin = scl;
  assign sideband_serial_data_pin_oe = oe;
  task automatic ph(input logic d, input logic c);
    repeat (QTR) @(negedge ref_clk);
    oe = d;
    scl = c;
  endtask : ph
  // start, or repeated start when the clock is low
  task automatic start();
    ph(1'b0, scl);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask : start
  // clock then stands still high until the next frame
  task automatic stop();
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
  endtask : stop
  task automatic bit_io(input logic b, output logic got);
    ph(~b, 1'b0);
    ph(~b, 1'b1);
    ph(~b, 1'b1);
    got = sideband_serial_data_pin;
    ph(~b, 1'b0);
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(d[i], g);
    bit_io(1'b1, ack);
  endtask : wr_byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, g);
  endtask : rd_byte
endmodule : sbc_master
`default_nettype wire

// ==== sideband_config_access_slave_test.sv ====
// self-checking bench for the sideband config access slave
`timescale 1ns/10ps
`default_nettype none
module sideband_config_access_slave_test;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr_strap = 3'h0;
  logic [31:0] cfg_rdata = 32'h0;
  logic cfg_rd_valid = 1'b0;
  wire scl;
  wire m_oe;
  wire sda;
  logic s_oe, s_out, wr_req, rd_req;
  logic [1:0] port;
  logic [11:0] addr;
  logic [3:0] be;
  logic [31:0] wdata;
  int failures = 0;
  int check_count = 0;
  int wr_n = 0;
  int rd_n = 0;
  int exp_wr = 0;
  int exp_rd = 0;
  int pend = 0;
  logic [31:0] seed = 32'h0D84;
  logic [31:0] cseed = 32'h0D84;
  logic [31:0] r, q, e_wdata, e_data;
  logic [1:0] e_port;
  logic [11:0] e_addr;
  logic [3:0] e_be;
  logic [7:0] b;
  // pulled-up open-drain data wire
  assign sda = ~(m_oe | (s_oe & ~s_out));
  initial forever #12.5 ref_clk = ~ref_clk;
  sbc_slave dut (.ref_clk(ref_clk), .rst(rst), .sideband_serial_clock_pin(scl),
    .sideband_serial_data_pin_in(sda), .sideband_serial_data_pin_out(s_out),
    .sideband_serial_data_pin_oe(s_oe), .addr_strap(addr_strap), .cfg_wr_req(wr_req),
    .cfg_rd_req(rd_req), .cfg_port(port), .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wdata),
    .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid));
  sbc_master m (.ref_clk(ref_clk), .sideband_serial_data_pin(sda),
    .sideband_serial_clock_pin(scl), .sideband_serial_data_pin_oe(m_oe));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] smb_ab(input logic rw);
    return {4'hB, addr_strap, rw};
  endfunction : smb_ab
  function automatic logic [7:0] i2c_ab(input logic rw);
    return {4'h7, addr_strap, rw};
  endfunction : i2c_ab
  task automatic rnd();
    repeat (32) seed = lfsr(seed);
    r = seed;
  endtask : rnd
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_ack(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_ack
  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    m.wr_byte(d, a);
    chk_ack(a, exp_ack);
  endtask : send
  // core side: requests are checked, reads answered after a random delay
  always @(negedge ref_clk) begin
    cfg_rd_valid = 1'b0;
    if (pend > 0) begin
      pend--;
      if (pend == 0) begin
        e_data = cseed;
        cfg_rdata = cseed;
        cfg_rd_valid = 1'b1;
      end
    end
    if (rd_req === 1'b1) begin
      rd_n++;
      chk_val({18'h0, port, addr}, {18'h0, e_port, e_addr});
      repeat (32) cseed = lfsr(cseed);
      pend = 1 + cseed[3:0];
    end
    if (wr_req === 1'b1) begin
      wr_n++;
      chk_val(wdata, e_wdata);
      chk_val({14'h0, port, addr, be}, {14'h0, e_port, e_addr, e_be});
    end
  end
  task automatic smb_read(input logic [7:0] off, input logic [7:0] pb);
    logic ok;
    ok = (pb <= 8'h03);
    e_port = pb[1:0];
    e_addr = {4'h0, off};
    m.start();
    send(smb_ab(1'b0), 1'b0);
    send(8'h08, 1'b0);
    send(off, 1'b0);
    send(pb, ~ok);
    m.stop();
    if (ok) begin
      exp_rd++;
      m.start();
      send(smb_ab(1'b0), 1'b0);
      send(8'h08, 1'b0);
      m.start();
      send(smb_ab(1'b1), 1'b0);
      m.rd_byte(1'b0, b);
      chk_val({24'h0, b}, {24'h0, e_data[7:0]});
      m.rd_byte(1'b1, b);
      chk_val({24'h0, b}, {24'h0, e_data[15:8]});
      m.stop();
    end
  endtask : smb_read
  task automatic i2c_write(input logic [2:0] code, input logic [1:0] pb, input logic [11:0] a12,
      input logic [3:0] ben, input logic [31:0] d, input logic extra);
    e_port = pb;
    e_addr = {a12[11:2], 2'b00};
    e_be = ben;
    e_wdata = d;
    m.start();
    send(i2c_ab(1'b0), 1'b0);
    send({5'h00, code}, 1'b0);
    send({7'h00, pb[1]}, 1'b0);
    send({pb[0], 1'b0, ben, a12[11:10]}, 1'b0);
    send(a12[9:2], 1'b0);
    for (int i = 3; i >= 0; i--) send(d[8*i +: 8], 1'b0);
    if (extra) send(8'hA5, 1'b1);
    m.stop();
    if (code == 3'h3) exp_wr++;
  endtask : i2c_write
  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    smb_read(8'hB4, 8'h01);
    for (int k = 0; k < 5; k++) begin
      rnd();
      addr_strap = r[2:0];
      repeat (8) @(negedge ref_clk);
      rnd();
      smb_read(r[7:0], {6'h0, r[9:8]});
      rnd();
      q = r;
      rnd();
      i2c_write(3'h3, q[1:0], q[15:4], (k < 2) ? {4{k[0]}} : q[19:16], r, k == 1);
    end
    smb_read(8'h10, 8'h04);
    m.start();
    send(smb_ab(1'b0), 1'b0);
    send(8'h09, 1'b1);
    send(8'h00, 1'b1);
    m.stop();
    i2c_write(3'h2, 2'h3, 12'hFFC, 4'hF, 32'h1234_5678, 1'b0);
    m.start();
    send({4'h5, addr_strap, 1'b0}, 1'b1);
    send(8'h08, 1'b1);
    m.stop();
    m.start();
    send(i2c_ab(1'b1), 1'b1);
    m.stop();
    chk_val(32'(wr_n), 32'(exp_wr));
    chk_val(32'(rd_n), 32'(exp_rd));
    summarize();
  end
  // about three times the roughly 9000 cycles the sequence needs
  initial begin
    repeat (30000) @(posedge ref_clk);
    failures++;
    summarize();
  end
  task automatic summarize();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
endmodule : sideband_config_access_slave_test
`default_nettype wire
